// ===== pkg/lft_pkg.sv
// constants and types of the display frame timing block
//****************************************************************
// Overview of operation
//****************************************************************
// Overview of operation
// - common and segment levels change at the slot ends made by the divider chain.
// - static multiplex divides the chosen source by 4 times 1 times prescale times 32.
// - two-common multiplex divides the chosen source by 2 times 2 times prescale times 32.
// - three-common multiplex divides the chosen source by 1 times 3 times prescale times 32.
// - four-common multiplex divides the chosen source by 1 times 4 times prescale times 32.
// - the source is the system clock over 256, the secondary oscillator or the slow oscillator.
// - control holds a 2-bit multiplex select, a 2-bit source select and a sleep-run bit.
// - a frame interrupt flag and its enable exist; software clears the flag while setting up.
// - the display is driven only while the enable bit of control is set, written last.
// - writing zero to all control bits stops the common and segment drive.
// - multiplex select 00, 01, 10, 11 means one, two, three or four active commons.
// - a pin is a segment driver when its enable bit is one, overriding its direction.
// - each pixel data bit sets one pixel at one common and segment crossing.
`default_nettype none
package lft_pkg;
    // register byte addresses
    localparam logic [11:0] ADDR_PRESCALE = 12'h0000;
    localparam logic [11:0] ADDR_SEG_EN   = 12'h0004;
    localparam logic [11:0] ADDR_CONTROL  = 12'h0008;
    localparam logic [11:0] ADDR_IRQ_STAT = 12'h000C;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h0010;
    localparam logic [11:0] ADDR_PIX_BASE = 12'h0020;
    localparam int          PIX_REGS      = 12;
    // geometry
    localparam int          NUM_SEG       = 24;
    localparam int          NUM_COM       = 4;
    localparam int          SEG_PER_REG   = 8;
    // control field positions
    localparam int          CTL_MUX_LSB   = 0;
    localparam int          CTL_SRC_LSB   = 2;
    localparam int          CTL_SLEEP_RUN = 6;
    localparam int          CTL_ENABLE    = 7;
    localparam int          IRQ_FRAME_BIT = 0;
    // reset values
    localparam logic [3:0]  RST_PRESCALE  = 4'h0;
    localparam logic [23:0] RST_SEG_EN    = 24'h00_0000;
    localparam logic [7:0]  RST_CONTROL   = 8'h00;
    localparam logic [7:0]  RST_PIXEL     = 8'h00;
    // divider figures
    localparam int          SYS_DIV       = 256;
    localparam int          FRAME_BASE    = 32;
    localparam int          SLOT_W        = 11;
    // multiplex modes
    typedef enum logic [1:0] {
        LFT_MUX_STATIC = 2'b00,
        LFT_MUX_TWO    = 2'b01,
        LFT_MUX_THREE  = 2'b10,
        LFT_MUX_FOUR   = 2'b11
    } lft_mux_t;
    // frame clock sources
    typedef enum logic [1:0] {
        LFT_SRC_SYS    = 2'b00,
        LFT_SRC_SECOND = 2'b01,
        LFT_SRC_SLOW   = 2'b10,
        LFT_SRC_NONE   = 2'b11
    } lft_src_t;
endpackage : lft_pkg
`default_nettype wire

// ===== logic/lft_frame_timing.sv
// display frame timing block: apb registers, frame divider, common and segment drive
`default_nettype none
module lft_frame_timing (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    // apb slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic             pready_out,
    output logic [31:0]      prdata_out,
    output logic             pslverr_out,
    // clock source ticks and power state
    input  wire logic        second_osc_tick_in,
    input  wire logic        slow_osc_tick_in,
    input  wire logic        sleep_in,
    // glass drive
    output logic [3:0]       com_en_out,
    output logic [3:0]       com_level_out,
    output logic [23:0]      seg_drive_en_out,
    output logic [23:0]      seg_level_out,
    // interrupt
    output logic             irq_out
);
    //****************************************************************
    // helper functions
    //****************************************************************
    // first divider stage per multiplex mode
    function automatic logic [2:0] pre_div(input logic [1:0] mux);
        unique case (lft_pkg::lft_mux_t'(mux))
            lft_pkg::LFT_MUX_STATIC: pre_div = 3'h4;
            lft_pkg::LFT_MUX_TWO:    pre_div = 3'h2;
            lft_pkg::LFT_MUX_THREE:  pre_div = 3'h1;
            lft_pkg::LFT_MUX_FOUR:   pre_div = 3'h1;
        endcase
    endfunction : pre_div

    // number of commons in use, also the slots per frame
    function automatic logic [2:0] com_count(input logic [1:0] mux);
        com_count = 3'({1'b0, mux} + 3'h1);
    endfunction : com_count

    //****************************************************************
    // register file and apb slave
    //****************************************************************
    logic [3:0]  prescale;
    logic [23:0] seg_en;
    logic [7:0]  control;
    logic        irq_flag;
    logic        irq_mask;
    logic [7:0]  pixel [lft_pkg::PIX_REGS];
    logic [31:0] prdata;
    logic        pslverr;
    logic [3:0]  next_prescale;
    logic [23:0] next_seg_en;
    logic [7:0]  next_control;
    logic        next_irq_flag;
    logic        next_irq_mask;
    logic [7:0]  next_pixel [lft_pkg::PIX_REGS];
    logic [31:0] next_prdata;
    logic        next_pslverr;
    logic        frame_end;
    logic        wr_en;
    logic        cfg_write;

    assign wr_en = psel_in & penable_in & pwrite_in;
    // any timing write restarts the frame so that the new ratio applies cleanly
    assign cfg_write = wr_en & (paddr_in == lft_pkg::ADDR_PRESCALE
                                || paddr_in == lft_pkg::ADDR_CONTROL);

    // decode writes in the access cycle and prepare read data during the setup cycle
    always_comb begin
        next_prescale = prescale;
        next_seg_en   = seg_en;
        next_control  = control;
        next_irq_mask = irq_mask;
        next_pixel    = pixel;
        next_prdata   = prdata;
        next_pslverr  = pslverr;
        // flag clear by writing one; a frame end in the same cycle wins
        next_irq_flag = irq_flag;
        if (wr_en && paddr_in == lft_pkg::ADDR_IRQ_STAT
            && pwdata_in[lft_pkg::IRQ_FRAME_BIT]) begin
            next_irq_flag = 1'b0;
        end
        if (frame_end) begin
            next_irq_flag = 1'b1;
        end
        if (wr_en) begin
            unique case (paddr_in)
                lft_pkg::ADDR_PRESCALE: next_prescale = pwdata_in[3:0];
                lft_pkg::ADDR_SEG_EN:   next_seg_en   = pwdata_in[23:0];
                lft_pkg::ADDR_CONTROL:  next_control  = pwdata_in[7:0];
                lft_pkg::ADDR_IRQ_MASK: next_irq_mask = pwdata_in[0];
                default: begin
                    for (int i = 0; i < lft_pkg::PIX_REGS; i++) begin
                        if (paddr_in == 12'(lft_pkg::ADDR_PIX_BASE + 4 * i)) begin
                            next_pixel[i] = pwdata_in[7:0];
                        end
                    end
                end
            endcase
        end
        if (psel_in && !penable_in) begin
            next_pslverr = 1'b0;
            unique case (paddr_in)
                lft_pkg::ADDR_PRESCALE: next_prdata = {28'h000_0000, prescale};
                lft_pkg::ADDR_SEG_EN:   next_prdata = {8'h00, seg_en};
                lft_pkg::ADDR_CONTROL:  next_prdata = {24'h00_0000, control};
                lft_pkg::ADDR_IRQ_STAT: next_prdata = {31'h0000_0000, irq_flag};
                lft_pkg::ADDR_IRQ_MASK: next_prdata = {31'h0000_0000, irq_mask};
                default: begin
                    // unmapped words answer zero with an error
                    next_prdata  = 32'h0000_0000;
                    next_pslverr = 1'b1;
                    for (int i = 0; i < lft_pkg::PIX_REGS; i++) begin
                        if (paddr_in == 12'(lft_pkg::ADDR_PIX_BASE + 4 * i)) begin
                            next_prdata  = {24'h00_0000, pixel[i]};
                            next_pslverr = 1'b0;
                        end
                    end
                end
            endcase
        end
    end

    // register stage of the register file
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            prescale <= lft_pkg::RST_PRESCALE;
            seg_en   <= lft_pkg::RST_SEG_EN;
            control  <= lft_pkg::RST_CONTROL;
            irq_flag <= 1'b0;
            irq_mask <= 1'b0;
            prdata   <= 32'h0000_0000;
            pslverr  <= 1'b0;
            for (int i = 0; i < lft_pkg::PIX_REGS; i++) begin
                pixel[i] <= lft_pkg::RST_PIXEL;
            end
        end else begin
            prescale <= next_prescale;
            seg_en   <= next_seg_en;
            control  <= next_control;
            irq_flag <= next_irq_flag;
            irq_mask <= next_irq_mask;
            prdata   <= next_prdata;
            pslverr  <= next_pslverr;
            pixel    <= next_pixel;
        end
    end

    assign pready_out  = 1'b1;  // zero wait states, read data registered at the end of setup
    assign prdata_out  = prdata;
    assign pslverr_out = pslverr & psel_in & penable_in;
    assign irq_out     = irq_flag & irq_mask;

    //****************************************************************
    // frame divider chain
    //****************************************************************
    logic [1:0]        mux;
    logic              enable;
    logic              run;
    logic              src_tick;
    logic              sys_tick;
    logic [7:0]        sys_cnt;
    logic [7:0]        next_sys_cnt;
    logic [lft_pkg::SLOT_W-1:0] slot_cnt;
    logic [lft_pkg::SLOT_W-1:0] next_slot_cnt;
    logic [lft_pkg::SLOT_W-1:0] slot_len;
    logic [1:0]        slot_idx;
    logic [1:0]        next_slot_idx;
    logic              slot_end;

    assign mux    = control[lft_pkg::CTL_MUX_LSB +: 2];
    assign enable = control[lft_pkg::CTL_ENABLE];
    // system clock stops in sleep; the drive then runs only if asked to
    assign run    = enable & (~sleep_in | control[lft_pkg::CTL_SLEEP_RUN]);
    assign sys_tick = (sys_cnt == 8'(lft_pkg::SYS_DIV - 1)) & ~sleep_in;
    // one slot is a frame shared among the used commons
    assign slot_len = lft_pkg::SLOT_W'(pre_div(mux) * prescale * lft_pkg::FRAME_BASE);

    // source selection; the spare code feeds no ticks
    always_comb begin
        unique case (lft_pkg::lft_src_t'(control[lft_pkg::CTL_SRC_LSB +: 2]))
            lft_pkg::LFT_SRC_SYS:    src_tick = sys_tick;
            lft_pkg::LFT_SRC_SECOND: src_tick = second_osc_tick_in;
            lft_pkg::LFT_SRC_SLOW:   src_tick = slow_osc_tick_in;
            lft_pkg::LFT_SRC_NONE:   src_tick = 1'b0;
        endcase
    end

    // slot ends on its last tick; a zero prescale never ends a slot
    assign slot_end  = run & src_tick & (slot_len != '0) & (slot_cnt == slot_len - 1'b1);
    assign frame_end = slot_end & ({1'b0, slot_idx} == com_count(mux) - 3'h1);

    // divider next values
    always_comb begin
        next_sys_cnt  = sleep_in ? sys_cnt : sys_cnt + 8'h01;
        next_slot_cnt = slot_cnt;
        next_slot_idx = slot_idx;
        if (!run || cfg_write) begin
            next_slot_cnt = '0;
            next_slot_idx = 2'h0;
        end else if (slot_end) begin
            next_slot_cnt = '0;
            next_slot_idx = frame_end ? 2'h0 : slot_idx + 2'h1;
        end else if (src_tick) begin
            next_slot_cnt = slot_cnt + 1'b1;
        end
    end

    // divider registers
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            sys_cnt  <= 8'h00;
            slot_cnt <= '0;
            slot_idx <= 2'h0;
        end else begin
            sys_cnt  <= next_sys_cnt;
            slot_cnt <= next_slot_cnt;
            slot_idx <= next_slot_idx;
        end
    end

    //****************************************************************
    // common and segment drive
    //****************************************************************
    logic        polarity;
    logic        next_polarity;
    logic [3:0]  next_com_en;
    logic [3:0]  next_com_level;
    logic [23:0] next_seg_drive_en;
    logic [23:0] next_seg_level;

    // levels refresh at slot ends and clear while disabled; polarity flips per frame for dc balance
    always_comb begin
        next_polarity     = polarity;
        next_com_en       = com_en_out;
        next_com_level    = com_level_out;
        next_seg_drive_en = enable ? seg_en : 24'h00_0000;
        next_seg_level    = seg_level_out;
        if (!enable) begin
            next_polarity  = 1'b0;
            next_com_en    = 4'h0;
            next_com_level = 4'h0;
            next_seg_level = 24'h00_0000;
        end else if (slot_end) begin
            next_polarity = frame_end ? ~polarity : polarity;
            for (int c = 0; c < lft_pkg::NUM_COM; c++) begin
                next_com_en[c]    = (3'(c) < com_count(mux));
                next_com_level[c] = next_com_en[c] & ((2'(c) == next_slot_idx) ^ polarity);
            end
            for (int s = 0; s < lft_pkg::NUM_SEG; s++) begin
                next_seg_level[s] = seg_en[s] & (polarity ^
                    pixel[next_slot_idx * 3 + s / lft_pkg::SEG_PER_REG]
                         [s % lft_pkg::SEG_PER_REG]);
            end
        end
    end

    // drive registers
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            polarity         <= 1'b0;
            com_en_out       <= 4'h0;
            com_level_out    <= 4'h0;
            seg_drive_en_out <= 24'h00_0000;
            seg_level_out    <= 24'h00_0000;
        end else begin
            polarity         <= next_polarity;
            com_en_out       <= next_com_en;
            com_level_out    <= next_com_level;
            seg_drive_en_out <= next_seg_drive_en;
            seg_level_out    <= next_seg_level;
        end
    end

    //****************************************************************
    // checks
    //****************************************************************
    logic [11:0] chk_ticks;
    logic [11:0] chk_expect;
    default clocking chk_clk @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    // independent tick count over one frame
    always_ff @(posedge clk_in) begin
        if (!resetn_in || !run || cfg_write || frame_end) begin
            chk_ticks <= 12'h000;
        end else if (src_tick) begin
            chk_ticks <= chk_ticks + 12'h001;
        end
    end
    always_comb begin
        unique case (mux)
            2'b00: chk_expect = 12'(4 * 1 * prescale * 32);
            2'b01: chk_expect = 12'(2 * 2 * prescale * 32);
            2'b10: chk_expect = 12'(1 * 3 * prescale * 32);
            2'b11: chk_expect = 12'(1 * 4 * prescale * 32);
        endcase
    end

    chk_frame_length: assert property (frame_end |-> chk_ticks + 12'h001 == chk_expect)
        else $error("frame length differs from divider ratio");
    chk_frame_flag_set: assert property (frame_end |=> irq_flag)
        else $error("frame end did not set flag");
    // a clear that does not meet a frame end must take effect at once
    chk_flag_clear: assert property (wr_en && paddr_in == lft_pkg::ADDR_IRQ_STAT
                                     && pwdata_in[lft_pkg::IRQ_FRAME_BIT] && !frame_end
                                     |=> !irq_flag)
        else $error("writing one did not clear the frame flag");
    chk_disable_quiet: assert property (!enable |=> com_level_out == 4'h0
                                         && seg_drive_en_out == 24'h00_0000)
        else $error("drive active while disabled");
    // mode taken from the slot end cycle, a control write may land there too
    chk_unused_commons: assert property (enable && slot_end |=>
                                         com_en_out == 4'((5'h1 << com_count($past(mux))) - 1))
        else $error("wrong commons enabled");
    chk_seg_override: assert property ((seg_drive_en_out & ~$past(seg_en)) == 24'h00_0000)
        else $error("segment driven without enable");
    chk_polarity_flip: assert property (frame_end |=> polarity != $past(polarity))
        else $error("polarity did not flip at frame end");
    chk_zero_prescale: assert property (prescale == 4'h0 |-> !slot_end)
        else $error("frame ran with zero prescale");
    chk_sys_spacing: assert property (sys_tick |=> !sys_tick [*8])
        else $error("system source ticks too close");
    chk_ctrl_write: assert property (wr_en && paddr_in == lft_pkg::ADDR_CONTROL |=>
                                     control == $past(pwdata_in[7:0]))
        else $error("control write not stored");

    cov_four_common_frame: cover property (frame_end && mux == 2'b11);
    cov_irq_raised: cover property ($rose(irq_out));
    cov_disable_after_run: cover property (enable ##1 !enable);
    cov_sleep_run: cover property (sleep_in && frame_end);
endmodule : lft_frame_timing
`default_nettype wire

// ===== bench/lft_glass_model.sv
// passive glass model: times common level changes and decodes lit pixels
`default_nettype none
module lft_glass_model (
    // clock
    input  wire logic        clk_in,
    // drive from the block
    input  wire logic [3:0]  com_en_in,
    input  wire logic [3:0]  com_level_in,
    input  wire logic [23:0] seg_en_in,
    input  wire logic [23:0] seg_level_in,
    // what the glass saw
    output logic [31:0]      gap_out,
    output logic [31:0]      changes_out,
    output logic [95:0]      pixels_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] cyc      = '0;
    logic [31:0] last_cyc = '0;
    logic [3:0]  last_com = '0;
    int          hits;
    initial begin
        gap_out = '0;
        changes_out = '0;
        pixels_out = '0;
    end
    // a common level change marks a slot end, so the gap is one slot time, or one frame in two-common mode
    always @(posedge clk_in) begin
        cyc <= cyc + 32'h0000_0001;
        last_com <= com_level_in;
        if (com_level_in !== last_com) begin
            gap_out <= cyc - last_cyc;
            last_cyc <= cyc;
            changes_out <= changes_out + 32'h0000_0001;
        end
    end
    // lit when segment equals the active common; two-common mode is ambiguous here
    always @(posedge clk_in) begin
        for (int c = 0; c < 4; c++) begin
            hits = 0;
            for (int o = 0; o < 4; o++) begin
                if (o != c && com_en_in[o] && com_level_in[o] == com_level_in[c]) hits++;
            end
            if (com_en_in[c] && hits == 0) begin
                for (int s = 0; s < 24; s++) begin
                    pixels_out[c*24+s] <= seg_en_in[s] & (seg_level_in[s] == com_level_in[c]);
                end
            end
        end
    end
endmodule : lft_glass_model
`default_nettype wire

// ===== bench/lft_frame_timing_bench.sv
// self-checking bench of the frame timing block beside a glass model
`default_nettype none
module lft_frame_timing_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // control without enable, prescale, segment enables, commons used, slot gap
    typedef struct packed {
        logic [7:0]  ctl;
        logic [3:0]  pre;
        logic [23:0] segment_line;
        logic [3:0]  com;
        logic [15:0] gap;
    } lft_row_t;
    logic        clk_in, resetn_in, psel_in, penable_in, pwrite_in, sleep_in;
    logic        second_osc_tick_in = 1'b0;
    logic        slow_osc_tick_in   = 1'b0;
    logic [11:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out, gap, changes, q;
    logic        pready_out, pslverr_out, irq_out, e;
    logic [3:0]  com_en_out, com_level_out;
    logic [23:0] seg_drive_en_out, seg_level_out;
    logic [95:0] pixels;
    int          err_count   = 0;
    int          comparisons = 0;
    int          tick_div    = 0;
    // slow ticks every 2 cycles, secondary ticks every 3
    lft_row_t    rows [6] = '{
        '{8'h08, 4'h1, 24'hFF_FFFF, 4'h1, 16'h0100},
        '{8'h09, 4'h1, 24'h00_00FF, 4'h3, 16'h0100},
        '{8'h0A, 4'h3, 24'hA5_0F3C, 4'h7, 16'h00C0},
        '{8'h0B, 4'hF, 24'hFF_FFFF, 4'hF, 16'h03C0},
        '{8'h07, 4'h2, 24'h80_0001, 4'hF, 16'h00C0},
        '{8'h03, 4'h1, 24'hFF_FFFF, 4'hF, 16'h2000}};
    logic [11:0] addrs [5] = '{lft_pkg::ADDR_PRESCALE, lft_pkg::ADDR_SEG_EN,
        lft_pkg::ADDR_CONTROL, lft_pkg::ADDR_IRQ_MASK, 12'h004C};
    logic [31:0] masks [5] = '{32'h0000_000F, 32'h00FF_FFFF, 32'h0000_00FF,
        32'h0000_0001, 32'h0000_00FF};

    lft_frame_timing dut_u (
        .clk_in(clk_in), .resetn_in(resetn_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .pready_out(pready_out), .prdata_out(prdata_out),
        .pslverr_out(pslverr_out), .second_osc_tick_in(second_osc_tick_in),
        .slow_osc_tick_in(slow_osc_tick_in), .sleep_in(sleep_in),
        .com_en_out(com_en_out), .com_level_out(com_level_out),
        .seg_drive_en_out(seg_drive_en_out), .seg_level_out(seg_level_out),
        .irq_out(irq_out));
    lft_glass_model glass_u (
        .clk_in(clk_in), .com_en_in(com_en_out), .com_level_in(com_level_out),
        .seg_en_in(seg_drive_en_out), .seg_level_in(seg_level_out),
        .gap_out(gap), .changes_out(changes), .pixels_out(pixels));

    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    // oscillator tick trains
    always @(posedge clk_in) begin
        tick_div <= tick_div + 1;
        slow_osc_tick_in <= (tick_div % 2 == 0);
        second_osc_tick_in <= (tick_div % 3 == 0);
    end
    // well past the whole sequence, which is bounded by the system source row
    initial begin
        repeat (90000) @(posedge clk_in);
        err_count++;
        summarize();
    end

    task automatic check(input logic [95:0] seen, input logic [95:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize();
        if (err_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize

    // one transfer: setup cycle, then access held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 64);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        check(n < 64, 1'b1);
    endtask : apb

    // bounded wait for a number of common level changes seen by the glass
    task automatic wait_changes(input int k);
        int          n;
        logic [31:0] base;
        base = changes;
        n = 0;
        while (changes < base + 32'(k) && n < 60000) begin
            @(posedge clk_in);
            n++;
        end
        check(n < 60000, 1'b1);
    endtask : wait_changes

    function automatic logic [7:0] pix_val(input int i);
        return 8'(i * 37 + 5);
    endfunction : pix_val

    // register i = com*3 + seg/8, bit seg%8
    function automatic logic [95:0] exp_pix(input logic [23:0] segment_line);
        logic [95:0] r;
        logic [7:0]  v;
        for (int c = 0; c < 4; c++) begin
            for (int s = 0; s < 24; s++) begin
                v = pix_val(c * 3 + s / 8);
                r[c*24+s] = segment_line[s] & v[s%8];
            end
        end
        return r;
    endfunction : exp_pix

    // setup order: prescale, segments, control, pixels, flag, enable last
    task automatic setup(input logic [7:0] ctl, input logic [3:0] pre, input logic [23:0] segment_line);
        apb(1'b1, lft_pkg::ADDR_PRESCALE, 32'(pre), q, e);
        apb(1'b1, lft_pkg::ADDR_SEG_EN, 32'(segment_line), q, e);
        apb(1'b1, lft_pkg::ADDR_CONTROL, 32'(ctl), q, e);
        @(posedge clk_in);
        #1;
        check({com_en_out, seg_drive_en_out}, '0);
        for (int i = 0; i < lft_pkg::PIX_REGS; i++) begin
            apb(1'b1, lft_pkg::ADDR_PIX_BASE + 12'(4 * i), 32'(pix_val(i)), q, e);
        end
        apb(1'b1, lft_pkg::ADDR_IRQ_STAT, 32'h0000_0001, q, e);
        apb(1'b1, lft_pkg::ADDR_IRQ_MASK, 32'h0000_0000, q, e);
        apb(1'b1, lft_pkg::ADDR_CONTROL, 32'(ctl) | 32'h0000_0080, q, e);
    endtask : setup

    initial begin
        {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in, sleep_in} = '0;
        resetn_in = 1'b0;
        repeat (8) @(posedge clk_in);
        #1;
        check({pready_out, com_en_out, seg_drive_en_out, irq_out}, 30'h2000_0000);
        @(posedge clk_in);
        resetn_in <= 1'b1;
        // reset value, writable bits and clearing of prescale, segments, control, mask and the last pixel register
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, addrs[i], '0, q, e);
            check(q, '0);
            apb(1'b1, addrs[i], 32'hFFFF_FFFF, q, e);
            apb(1'b0, addrs[i], '0, q, e);
            check(q, masks[i]);
            apb(1'b1, addrs[i], '0, q, e);
        end
        // a hole between the mask and the pixel words answers with an error
        apb(1'b0, 12'h0014, '0, q, e);
        check({e, q}, 33'h1_0000_0000);
        // every multiplex mode and source, gap in cycles between common changes;
        // two-common levels only change once a frame, so that row gives a frame
        for (int r = 0; r < 6; r++) begin
            setup(rows[r].ctl, rows[r].pre, rows[r].segment_line);
            wait_changes(6);
            check(gap, 32'(rows[r].gap));
            check(com_en_out, rows[r].com);
            check(seg_drive_en_out, rows[r].segment_line);
            if (rows[r].ctl[1:0] == 2'b11) begin
                check(pixels, exp_pix(rows[r].segment_line));
            end
        end
        // flag sets while masked, then drives the line, then clears
        setup(8'h0B, 4'h1, 24'hFF_FFFF);
        wait_changes(5);
        apb(1'b0, lft_pkg::ADDR_IRQ_STAT, '0, q, e);
        check({irq_out, q}, 33'h0_0000_0001);
        apb(1'b1, lft_pkg::ADDR_IRQ_MASK, 32'h0000_0001, q, e);
        #1;
        check(irq_out, 1'b1);
        apb(1'b1, lft_pkg::ADDR_IRQ_STAT, 32'h0000_0001, q, e);
        #1;
        check(irq_out, 1'b0);
        // asleep without the run bit the drive stands; with it slots go on
        @(posedge clk_in);
        sleep_in <= 1'b1;
        repeat (20) @(posedge clk_in);
        q = changes;
        repeat (300) @(posedge clk_in);
        check(changes - q, '0);
        setup(8'h4B, 4'h1, 24'hFF_FFFF);
        wait_changes(6);
        check(gap, 32'h0000_0040);
        sleep_in <= 1'b0;
        // zero prescale, then the empty source: no slots at all
        for (int i = 0; i < 2; i++) begin
            setup(i ? 8'h0F : 8'h0B, i ? 4'h1 : 4'h0, 24'hFF_FFFF);
            repeat (4) @(posedge clk_in);
            q = changes;
            repeat (300) @(posedge clk_in);
            check(changes - q, '0);
        end
        // all zeros to control stops the drive one edge later
        setup(8'h0B, 4'h1, 24'hFF_FFFF);
        wait_changes(2);
        apb(1'b1, lft_pkg::ADDR_CONTROL, '0, q, e);
        @(posedge clk_in);
        #1;
        check({com_en_out, com_level_out, seg_drive_en_out, seg_level_out}, '0);
        summarize();
    end
endmodule : lft_frame_timing_bench
`default_nettype wire
